// ### rtl/pem_port_e_mux.sv
// Summary of operation
// - queue status on pins 6:5 in expanded modes
// - normal write once, special ignores first write
// - eclk disable writable only in single-chip modes
// - pin 4 is E clock unless disabled or, in single-chip modes, stretched
// - E pin input in peripheral, else output
// - low strobe output in expanded modes except normal narrow
// - narrow normal mode keeps strobe pin driven high for the cycle after the init cycle
// - strobe pin zero at E fall tags in special expanded modes
// - read/write pin output in expanded modes only; peripheral loads the enable clear and cannot write it
// - calibration enable anytime, drives pin 7 unless it is data enable or inverted E
// - pin 7 data enable or inverted E
// - inverted-E select ignored in single/peripheral
// - inverted E is exact inverse of E
// - port e pull-ups only on pins that are inputs
// - port e pull-ups on pins 7, 3:0
// - port A/B pull-ups off on bus
// - port G/H pull devices follow enable
// - reduced drive per port, all outputs
// - pull and drive registers absent in peripheral
// - alternate function overrides pin direction
`default_nettype none
module pem_port_e_mux (
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	input  wire logic [2:0]  i_mode,
	input  wire logic [3:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	input  wire logic        i_eclk,
	input  wire logic        i_eclk_stretch,
	input  wire logic [1:0]  i_queue_status,
	input  wire logic        i_low_byte_strobe,
	input  wire logic        i_rw,
	input  wire logic        i_data_bus_enable_n,
	input  wire logic        i_cal_ref,
	input  wire logic        i_clkgen_test,
	input  wire logic        i_tag_enable,
	input  wire logic [7:0]  i_porte_direction,
	input  wire logic [7:0]  i_porte_gpio_out,
	input  wire logic [7:0]  i_pe_in,
	output logic      [7:0]  o_pe_out,
	output logic      [7:0]  o_pe_oe,
	output logic      [7:0]  o_porte_gpio_in,
	output logic             o_eclk_in,
	output logic             o_tag_low_byte,
	output logic             o_porta_pullup_en,
	output logic             o_portb_pullup_en,
	output logic      [7:0]  o_porte_pullup_en,
	output logic             o_portg_pull_en,
	output logic             o_porth_pull_en,
	output logic      [4:0]  o_port_low_drive
);
	import pem_pkg::*;

	// ------------------------------------------------------------------
	// mode decoding
	// ------------------------------------------------------------------
	function automatic logic f_single(input logic [2:0] m);
		f_single = (m == MODE_NORM_SINGLE) || (m == MODE_SPEC_SINGLE);
	endfunction : f_single

	function automatic logic f_special(input logic [2:0] m);
		f_special = !m[2];
	endfunction : f_special

	function automatic logic f_periph(input logic [2:0] m);
		f_periph = (m == MODE_PERIPHERAL);
	endfunction : f_periph

	wire logic m_single   = f_single(i_mode);
	wire logic m_special  = f_special(i_mode);
	wire logic m_periph   = f_periph(i_mode);
	wire logic m_expanded = !m_single && !m_periph;
	wire logic m_nnarrow  = (i_mode == MODE_NORM_NARROW);

	// ------------------------------------------------------------------
	// state and registers
	// ------------------------------------------------------------------
	pem_state_t st_q;
	logic [7:0] assign_q;
	logic [7:0] pullup_q;
	logic [7:0] drive_q;
	logic       assign_seen_q;
	logic       no_ext_eclk_seen_q;
	logic       drive_seen_q;
	logic       wait_q;
	logic       eclk_prev_q;

	wire logic [7:0] rst_assign = m_periph ? RST_ASSIGN_PERIPH :
		(i_mode == MODE_NORM_SINGLE) ? RST_ASSIGN_NORM_SINGLE :
		m_special ? RST_ASSIGN_SPEC : RST_ASSIGN_NORM_EXP;

	// ------------------------------------------------------------------
	// avalon slave: waitrequest high until one cycle after a request
	// ------------------------------------------------------------------
	wire logic req      = (i_avs_read || i_avs_write) && (st_q == ST_RUN);
	wire logic acc      = req && !wait_q;
	wire logic hit_asg  = (i_avs_address == OFS_ASSIGN) && !m_periph;
	wire logic hit_pull = (i_avs_address == OFS_PULLUP) && !m_periph;
	wire logic hit_drv  = (i_avs_address == OFS_DRIVE) && !m_periph;
	wire logic wr_lane  = acc && i_avs_write && i_avs_byteenable[0];
	wire logic wr_asg   = wr_lane && hit_asg;
	wire logic wr_pull  = wr_lane && hit_pull;
	wire logic wr_drv   = wr_lane && hit_drv;

	wire logic [7:0] rd_byte = hit_asg ? assign_q :
		hit_pull ? pullup_q :
		hit_drv ? drive_q : 8'h00;

	// normal: first write only; special: every write but the first
	wire logic once_ok  = m_special ? assign_seen_q : !assign_seen_q;
	wire logic drive_ok = m_special ? drive_seen_q : !drive_seen_q;
	wire logic no_ext_eclk_ok = (i_mode == MODE_SPEC_SINGLE) ||
		((i_mode == MODE_NORM_SINGLE) && !no_ext_eclk_seen_q);

	wire logic [7:0] asg_mask = {once_ok, m_special && assign_seen_q, once_ok, no_ext_eclk_ok,
		once_ok, once_ok, 1'b1, once_ok};
	wire logic [7:0] asg_next = (assign_q & ~asg_mask) | (i_avs_writedata[7:0] & asg_mask);

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			st_q <= ST_INIT;
		end else begin
			st_q <= ST_RUN;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			wait_q         <= 1'b1;
			o_avs_readdata <= 32'h0000_0000;
		end else begin
			wait_q <= !(req && wait_q);
			if (req && wait_q) begin
				o_avs_readdata <= {24'h00_0000, rd_byte};
			end
		end
	end

	// reset values depend on the mode, so they load in the init cycle
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			assign_q      <= 8'h00;
			assign_seen_q <= 1'b0;
			no_ext_eclk_seen_q  <= 1'b0;
		end else if (st_q == ST_INIT) begin
			assign_q <= rst_assign;
		end else if (wr_asg) begin
			assign_q      <= asg_next;
			assign_seen_q <= 1'b1;
			no_ext_eclk_seen_q  <= no_ext_eclk_seen_q || (i_mode == MODE_NORM_SINGLE);
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			pullup_q     <= RST_PULLUP;
			drive_q      <= RST_DRIVE;
			drive_seen_q <= 1'b0;
		end else begin
			if (wr_pull) begin
				pullup_q <= i_avs_writedata[7:0] & PORT_FIELDS_MASK;
			end
			if (wr_drv) begin
				drive_seen_q <= 1'b1;
				if (drive_ok) begin
					drive_q <= i_avs_writedata[7:0] & PORT_FIELDS_MASK;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// effective pin functions
	// ------------------------------------------------------------------
	wire logic a_no_data_bus_en  = assign_q[B_NO_DATA_BUS_EN];
	wire logic a_cgm   = assign_q[B_CLKGEN_TEST_EN];
	wire logic a_pipe  = assign_q[B_QUEUE_STATUS_OUT];
	wire logic a_no_ext_eclk = assign_q[B_NO_EXT_ECLK];
	wire logic a_lstr  = assign_q[B_LOW_STROBE_EN];
	wire logic a_rw_pin_en  = assign_q[B_RW_PIN_EN];
	wire logic a_cal   = assign_q[B_CAL_REF_EN];
	wire logic a_inve  = assign_q[B_PE7_INV_ECLK_SEL];

	wire logic f7_bus  = m_expanded && !a_no_data_bus_en;
	wire logic f7_cal  = !f7_bus && a_cal;
	wire logic f7_val  = a_inve ? !i_eclk : i_data_bus_enable_n;
	wire logic f6_pipe = a_pipe && m_expanded;
	wire logic f6_test = !f6_pipe && a_cgm && m_special && !m_single;
	wire logic f5_pipe = f6_pipe;
	wire logic f4_eclk = !a_no_ext_eclk && !m_periph && !(m_single && i_eclk_stretch);
	// E is an input in peripheral mode whatever the disable bit holds
	wire logic f4_in   = m_periph;
	wire logic f3_lstr = a_lstr && m_expanded && !m_nnarrow;
	wire logic f2_rw   = a_rw_pin_en && !m_single;

	// alternate functions take the pin away from the direction register
	wire logic [7:0] alt_sel = {f7_bus || f7_cal, f6_pipe || f6_test, f5_pipe,
		f4_eclk || f4_in, f3_lstr, f2_rw, 2'b00};
	wire logic [7:0] alt_val = {f7_bus ? f7_val : i_cal_ref,
		f6_pipe ? i_queue_status[1] : i_clkgen_test, i_queue_status[0],
		i_eclk, i_low_byte_strobe, i_rw, 2'b00};
	wire logic [7:0] alt_oe  = {alt_sel[7:5], f4_eclk, alt_sel[3:2], 2'b00};

	wire logic       hold_strobe = (st_q == ST_INIT) && m_nnarrow;
	wire logic [7:0] gp_oe   = i_porte_direction & PE_OUT_CAPABLE;
	wire logic [7:0] pe_oe_d = ((alt_sel & alt_oe) | (~alt_sel & gp_oe)) |
		{4'h0, hold_strobe, 3'h0};
	wire logic [7:0] pe_out_d = ((alt_sel & alt_val) | (~alt_sel & i_porte_gpio_out)) |
		{4'h0, hold_strobe, 3'h0};

	// eclk_prev_q resets low, so no false falling edge follows reset
	wire logic tag_d = m_special && m_expanded && a_lstr && i_tag_enable &&
		eclk_prev_q && !i_eclk && !i_pe_in[3];

	// ------------------------------------------------------------------
	// pull and drive controls
	// ------------------------------------------------------------------
	wire logic [7:0] pe_pull_d = {8{pullup_q[B_PORTE]}} & PE_PULL_PINS & ~pe_oe_d;
	wire logic       pa_pull_d = pullup_q[B_PORTA] && !m_expanded && !m_periph;
	wire logic       pb_pull_d = pullup_q[B_PORTB] && !m_expanded && !m_periph;

	// ------------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_pe_out <= 8'h08;
			o_pe_oe  <= 8'h08;
		end else begin
			o_pe_out <= pe_out_d;
			o_pe_oe  <= pe_oe_d;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_porte_gpio_in <= 8'h00;
			o_eclk_in       <= 1'b0;
			o_tag_low_byte  <= 1'b0;
			eclk_prev_q     <= 1'b0;
		end else begin
			o_porte_gpio_in <= i_pe_in;
			o_eclk_in       <= f4_in && i_pe_in[4];
			o_tag_low_byte  <= tag_d;
			eclk_prev_q     <= i_eclk;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_porta_pullup_en <= 1'b0;
			o_portb_pullup_en <= 1'b0;
			o_porte_pullup_en <= 8'h00;
			o_portg_pull_en   <= 1'b0;
			o_porth_pull_en   <= 1'b0;
			o_port_low_drive  <= 5'h00;
		end else begin
			o_porta_pullup_en <= pa_pull_d;
			o_portb_pullup_en <= pb_pull_d;
			o_porte_pullup_en <= pe_pull_d;
			o_portg_pull_en   <= pullup_q[B_PORTG];
			o_porth_pull_en   <= pullup_q[B_PORTH];
			o_port_low_drive  <= drive_q[4:0];
		end
	end

	assign o_avs_waitrequest = wait_q;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	wait_answer_a: assert property ((req && o_avs_waitrequest) |-> ##1 !o_avs_waitrequest ##1 o_avs_waitrequest)
		else $error("waitrequest did not drop for exactly one cycle");
	normal_once_a: assert property ((wr_asg && !m_special && assign_seen_q) |=>
		$stable(assign_q[B_QUEUE_STATUS_OUT]))
		else $error("second write changed a write-once bit");
	special_first_a: assert property ((wr_asg && m_special && !assign_seen_q) |=>
		$stable(assign_q[B_RW_PIN_EN]))
		else $error("first special write was not ignored");
	eclk_lock_a: assert property ((wr_asg && m_expanded) |=> $stable(assign_q[B_NO_EXT_ECLK]))
		else $error("eclk disable bit written outside single-chip");
	single_lock_a: assert property ((wr_asg && i_mode == MODE_NORM_SINGLE && no_ext_eclk_seen_q) |=>
		$stable(assign_q[B_NO_EXT_ECLK]))
		else $error("eclk disable bit written twice in normal single-chip");
	cal_write_a: assert property (wr_asg |=>
		assign_q[B_CAL_REF_EN] == $past(i_avs_writedata[B_CAL_REF_EN]))
		else $error("calibration enable write refused");

	// ------------------------------------------------------------------
	// reduced drive and pull registers
	// ------------------------------------------------------------------
	drive_lock_a: assert property ((wr_drv && !drive_ok) |=> $stable(drive_q))
		else $error("protected drive write took effect");
	low_drive_a: assert property ((wr_drv && drive_ok) |-> ##2
		o_port_low_drive == $past(i_avs_writedata[4:0], 2))
		else $error("reduced drive output does not follow its register");
	gh_pull_a: assert property (wr_pull |-> ##2
		(o_portg_pull_en == $past(i_avs_writedata[B_PORTG], 2) &&
		o_porth_pull_en == $past(i_avs_writedata[B_PORTH], 2)))
		else $error("port g/h pull enables do not follow their bits");

	// ------------------------------------------------------------------
	// pin functions, checked from the run state on, strobe hold in the init state
	// ------------------------------------------------------------------
	inv_eclk_a: assert property ((st_q == ST_RUN && f7_bus && a_inve) |=>
		(o_pe_oe[7] && o_pe_out[7] == !$past(i_eclk)))
		else $error("pin 7 is not the inverse of E");
	dbe_pin_a: assert property ((st_q == ST_RUN && m_expanded && !a_no_data_bus_en && !a_inve) |=>
		(o_pe_oe[7] && o_pe_out[7] == $past(i_data_bus_enable_n)))
		else $error("pin 7 does not carry the data bus enable");
	cal_pin_a: assert property ((st_q == ST_RUN && (!m_expanded || a_no_data_bus_en) && a_cal) |=>
		(o_pe_oe[7] && o_pe_out[7] == $past(i_cal_ref)))
		else $error("pin 7 does not carry the calibration reference");
	gp_pin7_a: assert property ((st_q == ST_RUN && (!m_expanded || a_no_data_bus_en) && !a_cal) |=>
		(o_pe_oe[7] == $past(i_porte_direction[7]) && o_pe_out[7] == $past(i_porte_gpio_out[7])))
		else $error("pin 7 is not general I/O");
	queue_out_a: assert property ((st_q == ST_RUN && a_pipe && m_expanded) |=>
		(o_pe_oe[6:5] == 2'b11 && o_pe_out[6:5] == $past(i_queue_status)))
		else $error("pins 6:5 do not carry the queue status");
	eclk_out_a: assert property ((st_q == ST_RUN && m_expanded && !a_no_ext_eclk) |=>
		(o_pe_oe[4] && o_pe_out[4] == $past(i_eclk)))
		else $error("pin 4 does not carry E");
	eclk_input_a: assert property ((st_q == ST_RUN && m_periph) |=>
		(!o_pe_oe[4] && o_eclk_in == $past(i_pe_in[4])))
		else $error("E pin is not an input in peripheral mode");
	strobe_out_a: assert property ((st_q == ST_RUN && a_lstr && m_expanded && !m_nnarrow) |=>
		(o_pe_oe[3] && o_pe_out[3] == $past(i_low_byte_strobe)))
		else $error("pin 3 does not carry the low strobe");
	strobe_gp_a: assert property ((st_q == ST_RUN && (m_single || m_nnarrow)) |=>
		(o_pe_oe[3] == $past(i_porte_direction[3])))
		else $error("strobe enable acted in single-chip or narrow mode");
	strobe_hold_a: assert property ((st_q == ST_INIT && m_nnarrow) |=> (o_pe_oe[3] && o_pe_out[3]))
		else $error("strobe pin not held high after reset");
	rw_pin_a: assert property ((st_q == ST_RUN && a_rw_pin_en && !m_single) |=>
		(o_pe_oe[2] && o_pe_out[2] == $past(i_rw)))
		else $error("pin 2 does not carry read/write");
	rw_single_a: assert property ((st_q == ST_RUN && m_single) |=>
		(o_pe_oe[2] == $past(i_porte_direction[2])))
		else $error("rw pin not general I/O in single-chip");

	// ------------------------------------------------------------------
	// pulls, register map and tagging
	// ------------------------------------------------------------------
	pe_pull_a: assert property ((o_porte_pullup_en & ~PE_PULL_PINS) == 8'h00 &&
		(o_porte_pullup_en & o_pe_oe) == 8'h00)
		else $error("port e pull-up on a wrong pin");
	ab_pull_a: assert property ((m_expanded || m_periph) |=>
		(!o_porta_pullup_en && !o_portb_pullup_en))
		else $error("port a/b pull-up active on the bus");
	periph_map_a: assert property ((req && o_avs_waitrequest && m_periph) |=>
		o_avs_readdata == 32'h0000_0000)
		else $error("register visible in peripheral mode");
	flags_reset_a: assert property ((st_q == ST_INIT) |->
		(!assign_seen_q && !drive_seen_q && !no_ext_eclk_seen_q))
		else $error("write flags survive reset");
	tag_edge_a: assert property (o_tag_low_byte |->
		($past(eclk_prev_q) && !$past(i_eclk) && m_special))
		else $error("tag outside falling E edge");

	cov_write_c: cover property (wr_asg ##2 wr_asg);
	cov_tag_c: cover property (o_tag_low_byte);
	cov_dbe_c: cover property (f7_bus && !a_inve ##1 o_pe_oe[7]);
	cov_periph_c: cover property (m_periph && f4_in ##1 o_eclk_in);
	cov_strobe_c: cover property (st_q == ST_INIT && m_nnarrow);
endmodule : pem_port_e_mux
`default_nettype wire

// ### rtl/pem_pkg.sv
`default_nettype none
package pem_pkg;
	// ------------------------------------------------------------------
	// operating modes (i_mode encoding)
	// ------------------------------------------------------------------
	localparam logic [2:0] MODE_SPEC_SINGLE  = 3'h0;
	localparam logic [2:0] MODE_SPEC_NARROW  = 3'h1;
	localparam logic [2:0] MODE_PERIPHERAL   = 3'h2;
	localparam logic [2:0] MODE_SPEC_WIDE    = 3'h3;
	localparam logic [2:0] MODE_NORM_SINGLE  = 3'h4;
	localparam logic [2:0] MODE_NORM_NARROW  = 3'h5;
	localparam logic [2:0] MODE_NORM_WIDE    = 3'h7;

	// ------------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------------
	localparam logic [3:0] OFS_ASSIGN = 4'h0;
	localparam logic [3:0] OFS_PULLUP = 4'h4;
	localparam logic [3:0] OFS_DRIVE  = 4'h8;

	// ------------------------------------------------------------------
	// port_e_function_assign fields
	// ------------------------------------------------------------------
	localparam int B_NO_DATA_BUS_EN    = 7;
	localparam int B_CLKGEN_TEST_EN    = 6;
	localparam int B_QUEUE_STATUS_OUT  = 5;
	localparam int B_NO_EXT_ECLK       = 4;
	localparam int B_LOW_STROBE_EN     = 3;
	localparam int B_RW_PIN_EN         = 2;
	localparam int B_CAL_REF_EN        = 1;
	localparam int B_PE7_INV_ECLK_SEL  = 0;

	// ------------------------------------------------------------------
	// pull-up and reduced-drive fields (same layout in both)
	// ------------------------------------------------------------------
	localparam int B_PORTA = 0;
	localparam int B_PORTB = 1;
	localparam int B_PORTE = 2;
	localparam int B_PORTG = 3;
	localparam int B_PORTH = 4;
	localparam logic [7:0] PORT_FIELDS_MASK = 8'h1F;

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_ASSIGN_NORM_EXP    = 8'h00;
	localparam logic [7:0] RST_ASSIGN_SPEC        = 8'h2C;
	localparam logic [7:0] RST_ASSIGN_PERIPH      = 8'hD0;
	localparam logic [7:0] RST_ASSIGN_NORM_SINGLE = 8'h90;
	localparam logic [7:0] RST_PULLUP             = 8'h00;
	localparam logic [7:0] RST_DRIVE              = 8'h00;

	// pull-ups exist on pins 7 and 3..0 of port e only
	localparam logic [7:0] PE_PULL_PINS = 8'h8F;
	// pins 1..0 of port e are inputs only
	localparam logic [7:0] PE_OUT_CAPABLE = 8'hFC;

	// ------------------------------------------------------------------
	// control state
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_INIT = 2'b01,
		ST_RUN  = 2'b10
	} pem_state_t;
endpackage : pem_pkg
`default_nettype wire

// ### tb/pem_ext_model.sv
`default_nettype none
module pem_ext_model (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_pe_out,
	input  wire logic [7:0] i_pe_oe,
	input  wire logic [7:0] i_pull_en,
	input  wire logic [7:0] i_ext_oe,
	input  wire logic [7:0] i_ext_val,
	output logic      [7:0] o_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] float_q = 8'h55;
	// ------------------------------------------------------------------
	// wire resolution
	// ------------------------------------------------------------------
	// an undriven pin without pull-up toggles so no stale level reads true
	always_ff @(posedge i_clk) begin
		float_q <= ~float_q;
	end
	wire logic [7:0] float_lvl = i_pull_en | float_q;
	assign o_pin = (i_pe_oe & i_pe_out) | (~i_pe_oe & i_ext_oe & i_ext_val) | (~i_pe_oe & ~i_ext_oe & float_lvl);
endmodule : pem_ext_model
`default_nettype wire

// ### tb/pem_port_e_mux_tb.sv
`default_nettype none
module pem_port_e_mux_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pem_pkg::*;
	typedef struct packed {
		logic [2:0] mode;
		logic [7:0] asg;
		logic [7:0] oe;
		logic [7:0] mask;
	} pem_row_t;
	localparam pem_row_t ROWS [7] = '{
		'{MODE_SPEC_SINGLE, RST_ASSIGN_SPEC, 8'h10, 8'hFF},
		'{MODE_SPEC_NARROW, RST_ASSIGN_SPEC, 8'hFC, 8'hFF},
		'{MODE_PERIPHERAL, 8'h00, 8'h40, 8'hFF},
		'{MODE_SPEC_WIDE, RST_ASSIGN_SPEC, 8'hFC, 8'hFF},
		'{MODE_NORM_SINGLE, RST_ASSIGN_NORM_SINGLE, 8'h00, 8'hFF},
		'{MODE_NORM_NARROW, RST_ASSIGN_NORM_EXP, 8'h90, 8'hFF},
		'{MODE_NORM_WIDE, RST_ASSIGN_NORM_EXP, 8'h90, 8'hFF}
	};
	logic        i_clk = 1'b0, i_reset = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0;
	logic [2:0]  i_mode = 3'h0;
	logic [3:0]  i_avs_address = 4'h0, i_avs_byteenable = 4'hF;
	logic [31:0] i_avs_writedata = 32'h00000000, o_avs_readdata, rd;
	logic        o_avs_waitrequest, i_eclk = 1'b0, i_eclk_stretch = 1'b0, i_rw = 1'b0;
	logic [1:0]  i_queue_status = 2'h0;
	logic        i_low_byte_strobe = 1'b0, i_data_bus_enable_n = 1'b1, i_cal_ref = 1'b0;
	logic        i_clkgen_test = 1'b0, i_tag_enable = 1'b0, seen;
	logic [7:0]  i_porte_direction = 8'h00, i_porte_gpio_out = 8'h00, i_pe_in, o_pe_out, o_pe_oe;
	logic [7:0]  o_porte_gpio_in, o_porte_pullup_en, ext_oe = 8'hFF, ext_val = 8'hA5;
	logic        o_eclk_in, o_tag_low_byte, o_porta_pullup_en, o_portb_pullup_en;
	logic        o_portg_pull_en, o_porth_pull_en;
	logic [4:0]  o_port_low_drive;
	int          errors = 0, checks = 0, cycles = 0;

	pem_port_e_mux pem_port_e_mux_i (.i_clk, .i_reset, .i_mode, .i_avs_address, .i_avs_read, .i_avs_write,
		.i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_eclk, .i_eclk_stretch,
		.i_queue_status, .i_low_byte_strobe, .i_rw, .i_data_bus_enable_n, .i_cal_ref, .i_clkgen_test,
		.i_tag_enable, .i_porte_direction, .i_porte_gpio_out, .i_pe_in, .o_pe_out, .o_pe_oe, .o_porte_gpio_in,
		.o_eclk_in, .o_tag_low_byte, .o_porta_pullup_en, .o_portb_pullup_en, .o_porte_pullup_en,
		.o_portg_pull_en, .o_porth_pull_en, .o_port_low_drive);
	pem_ext_model pem_ext_model_i (.i_clk, .i_pe_out(o_pe_out), .i_pe_oe(o_pe_oe), .i_pull_en(o_porte_pullup_en),
		.i_ext_oe(ext_oe), .i_ext_val(ext_val), .o_pin(i_pe_in));

	// ------------------------------------------------------------------
	// clock, timeout and report
	// ------------------------------------------------------------------
	always #5 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : complete_run
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t reg got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_reg
	task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t pin got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_pin
	// ------------------------------------------------------------------
	// bus and sequencing helpers
	// ------------------------------------------------------------------
	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_avs_write     <= wr;
		i_avs_read      <= ~wr;
		i_avs_address   <= a;
		i_avs_writedata <= {24'h000000, d};
		do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
		rd = o_avs_readdata;
		i_avs_write <= 1'b0;
		i_avs_read  <= 1'b0;
	endtask : bus
	task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		chk_reg(rd, {24'h000000, exp});
	endtask : rchk
	task automatic settle();
		repeat (4) @(posedge i_clk);
	endtask : settle
	task automatic do_reset(input logic [2:0] m);
		@(posedge i_clk);
		i_reset <= 1'b1;
		i_mode  <= m;
		repeat (10) @(posedge i_clk);
		chk_pin({5'h00, o_avs_waitrequest, o_pe_out[3], o_pe_oe[3]}, 8'h07);
		i_reset <= 1'b0;
		repeat (2) @(posedge i_clk);
	endtask : do_reset

	initial begin
		foreach (ROWS[n]) begin
			do_reset(ROWS[n].mode);
			rchk(OFS_ASSIGN, ROWS[n].asg);
			settle();
			chk_pin(o_pe_oe & ROWS[n].mask, ROWS[n].oe);
			chk_pin(o_porte_gpio_in & ~ROWS[n].oe & ROWS[n].mask, 8'hA5 & ~ROWS[n].oe & ROWS[n].mask);
		end
		$display("test mode table done");
		do_reset(MODE_NORM_WIDE);
		bus(1'b1, OFS_ASSIGN, 8'h0C);
		bus(1'b1, OFS_ASSIGN, 8'h00);
		rchk(OFS_ASSIGN, 8'h0C);
		i_rw              <= 1'b1;
		i_low_byte_strobe <= 1'b1;
		bus(1'b1, OFS_PULLUP, 8'h03);
		settle();
		chk_pin(o_pe_oe, 8'h9C);
		chk_pin({4'h0, o_pe_out[3:2], o_portb_pullup_en, o_porta_pullup_en}, 8'h0C);
		$display("test normal write once done");
		do_reset(MODE_SPEC_WIDE);
		i_tag_enable      <= 1'b1;
		i_low_byte_strobe <= 1'b0;
		i_queue_status    <= 2'h2;
		i_eclk            <= 1'b1;
		settle();
		i_eclk <= 1'b0;
		seen = 1'b0;
		repeat (6) begin
			@(posedge i_clk);
			if (o_tag_low_byte === 1'b1) seen = 1'b1;
		end
		chk_pin({7'h00, seen}, 8'h01);
		chk_pin({6'h00, o_pe_out[6:5]}, 8'h02);
		bus(1'b1, OFS_ASSIGN, 8'h01);
		rchk(OFS_ASSIGN, 8'h2C);
		bus(1'b1, OFS_ASSIGN, 8'h31);
		rchk(OFS_ASSIGN, 8'h21);
		i_eclk <= 1'b1;
		settle();
		chk_pin({6'h00, o_pe_out[7], o_pe_out[4]}, 8'h01);
		i_eclk <= 1'b0;
		settle();
		chk_pin({6'h00, o_pe_out[7], o_pe_out[4]}, 8'h02);
		do_reset(MODE_SPEC_WIDE);
		bus(1'b1, OFS_ASSIGN, 8'h21);
		rchk(OFS_ASSIGN, 8'h2C);
		$display("test special expanded done");
		do_reset(MODE_NORM_SINGLE);
		bus(1'b1, OFS_ASSIGN, 8'h80);
		bus(1'b1, OFS_ASSIGN, 8'h92);
		rchk(OFS_ASSIGN, 8'h82);
		i_cal_ref <= 1'b1;
		settle();
		chk_pin({5'h00, o_pe_oe[7], o_pe_out[7], o_pe_oe[4]}, 8'h07);
		i_eclk_stretch <= 1'b1;
		settle();
		chk_pin({5'h00, o_pe_oe[7], o_pe_out[7], o_pe_oe[4]}, 8'h06);
		$display("test normal single done");
		do_reset(MODE_SPEC_SINGLE);
		i_porte_direction <= 8'h08;
		ext_oe            <= 8'h00;
		bus(1'b1, OFS_PULLUP, 8'hFF);
		rchk(OFS_PULLUP, 8'h1F);
		settle();
		chk_pin(o_porte_pullup_en, 8'h87);
		chk_pin(o_porte_gpio_in & 8'h87, 8'h87);
		chk_pin({3'h0, o_porth_pull_en, o_portg_pull_en, 1'b0, o_portb_pullup_en, o_porta_pullup_en}, 8'h1B);
		bus(1'b1, OFS_DRIVE, 8'h1F);
		rchk(OFS_DRIVE, 8'h00);
		bus(1'b1, OFS_DRIVE, 8'h15);
		rchk(OFS_DRIVE, 8'h15);
		settle();
		chk_pin({3'h0, o_port_low_drive}, 8'h15);
		rchk(4'hC, 8'h00);
		do_reset(MODE_PERIPHERAL);
		bus(1'b1, OFS_PULLUP, 8'h1F);
		rchk(OFS_PULLUP, 8'h00);
		ext_oe  <= 8'hFF;
		ext_val <= 8'h10;
		settle();
		chk_pin({6'h00, o_pe_oe[4], o_eclk_in}, 8'h01);
		$display("test pull and drive done");
		complete_run();
	end
endmodule : pem_port_e_mux_tb
`default_nettype wire
